// ===== include/bdm_pkg.sv
// How it works
// - Status bits 7 to 5 read zero.
// - Active-low watchdog expiry flag in bit 4.
// - Active-low sleep flag in bit 3.
// - Bit 2 set on zero result.
// - Bit 1 is nibble carry for add/subtract.
// - Bit 0 is msb carry for add/subtract.
// - Subtract adds two's complement; carries mean no borrow.
// - Power reset sets power flags, clears arithmetic.
// - Peripheral area at bank offsets 0Ch to 1Fh.
// - Up to 80 general bytes after peripheral area.
// - Sixteen common bytes shared by all banks.
// - Unimplemented locations read zero.
// - General RAM reachable linearly through indirect pointer.
// - Flag-affecting op ignores status flag write.
// - 12-bit address: 5 bank, 7 offset bits.
// - Core registers fill first 12 offsets everywhere.
// - Bank select register picks direct-access bank.
package bdm_pkg;

  localparam int DATA_W       = 8;
  localparam int NIB_W        = 4;
  localparam int PTR_W        = 16;
  localparam int BANK_W       = 5;
  localparam int OFF_W        = 7;
  localparam int GPR_BYTES    = 80;
  localparam int COMMON_BYTES = 16;
  localparam int COMMON_IDX_W = 4;

  localparam logic [OFF_W-1:0] OFF_STATUS     = 7'h03;
  localparam logic [OFF_W-1:0] OFF_PTR_LO     = 7'h04;
  localparam logic [OFF_W-1:0] OFF_PTR_HI     = 7'h05;
  localparam logic [OFF_W-1:0] OFF_BANK_SEL   = 7'h08;
  localparam logic [OFF_W-1:0] OFF_CORE_LAST  = 7'h0b;
  localparam logic [OFF_W-1:0] OFF_PERIPH_END = 7'h1f;
  localparam logic [OFF_W-1:0] OFF_GPR_FIRST  = 7'h20;
  localparam logic [OFF_W-1:0] OFF_GPR_LAST   = 7'h6f;

  localparam logic [PTR_W-1:0] LINEAR_BASE  = 16'h2000;
  localparam logic [PTR_W-1:0] BANKED_LIMIT = 16'h1000;
  localparam int               PTR_PROG_BIT = 15;

  localparam int BIT_WDT   = 4;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_Z     = 2;
  localparam int BIT_DC    = 1;
  localparam int BIT_C     = 0;

  localparam logic RST_POWER_FLAG = 1'b1;
  localparam logic RST_ARITH_FLAG = 1'b0;

  localparam int               AXI_ADDR_W   = 8;
  localparam logic [7:0]       AXI_STATUS   = 8'h00;
  localparam logic [7:0]       AXI_BANK_SEL = 8'h04;
  localparam logic [7:0]       AXI_PTR      = 8'h08;
  localparam logic [7:0]       AXI_IDATA    = 8'h0c;
  localparam logic [1:0]       RESP_OKAY    = 2'b00;
  localparam logic [1:0]       RESP_SLVERR  = 2'b10;

  typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_LOGIC} bdm_alu_e;

  typedef enum logic [2:0] {
    RGN_NONE, RGN_STATUS, RGN_PTR_LO, RGN_PTR_HI, RGN_BANK, RGN_PERIPH, RGN_GPR, RGN_COMMON
  } bdm_region_e;

endpackage

// ===== src/bdm_alu_flags.sv
`timescale 1ns/1ps
module bdm_alu_flags
  import bdm_pkg::*;
(
  input  wire bdm_alu_e          kind,
  input  wire logic [DATA_W-1:0] a,
  input  wire logic [DATA_W-1:0] b,
  input  wire logic [DATA_W-1:0] logic_res,
  output logic      [DATA_W-1:0] result,
  output logic                   zero,
  output logic                   nib_carry,
  output logic                   msb_carry
);

  logic              is_sub;
  logic [DATA_W-1:0] b_eff;
  logic [DATA_W:0]   sum;
  logic [NIB_W:0]    low_sum;

  // Subtraction adds the inverted operand plus one, so carry set means no borrow.
  assign is_sub  = (kind == ALU_SUB);
  assign b_eff   = is_sub ? ~b : b;
  assign sum     = {1'b0, a} + {1'b0, b_eff} + {{DATA_W{1'b0}}, is_sub};
  assign low_sum = {1'b0, a[NIB_W-1:0]} + {1'b0, b_eff[NIB_W-1:0]} + {{NIB_W{1'b0}}, is_sub};

  assign result    = (kind == ALU_LOGIC) ? logic_res : sum[DATA_W-1:0];
  assign zero      = (result == '0);
  assign nib_carry = low_sum[NIB_W];
  assign msb_carry = sum[DATA_W];

endmodule

// ===== src/bdm_top.sv
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module bdm_top
  import bdm_pkg::*;
#(
  parameter int GPR_BANKS = 6
)
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  input  wire logic                  supply_drop_reset,
  input  wire logic                  watchdog_clear_instr,
  input  wire logic                  sleep_instr,
  input  wire logic                  watchdog_expire,
  input  wire logic                  mem_req,
  input  wire logic                  mem_we,
  input  wire logic                  mem_indirect,
  input  wire logic [OFF_W-1:0]      mem_offset,
  input  wire logic [DATA_W-1:0]     mem_wdata,
  output logic      [DATA_W-1:0]     mem_rdata,
  input  wire logic                  alu_valid,
  input  wire bdm_alu_e              alu_kind,
  input  wire logic [DATA_W-1:0]     alu_a,
  input  wire logic [DATA_W-1:0]     alu_b,
  input  wire logic [DATA_W-1:0]     alu_logic_res,
  output logic      [DATA_W-1:0]     alu_result,
  output logic      [DATA_W-1:0]     arith_reset_status,
  output logic      [BANK_W-1:0]     bank_select_register,
  output logic                       periph_sel,
  output logic      [11:0]           periph_addr,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic      [1:0]            s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  localparam int GPR_TOTAL = GPR_BANKS * GPR_BYTES;
  localparam int GIW       = $clog2(GPR_TOTAL);

  typedef struct packed {
    logic                  wdt_n;
    logic                  sleep_n;
    logic                  z;
    logic                  dc;
    logic                  c;
    logic [BANK_W-1:0]     bank;
    logic [PTR_W-1:0]      ptr;
    logic [DATA_W-1:0]     mem_rdata;
    logic [DATA_W-1:0]     alu_result;
    logic                  periph_sel;
    logic [11:0]           periph_addr;
    logic                  aw_got;
    logic                  w_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } bdm_state_s;

  bdm_state_s        s;
  bdm_state_s        next_s;
  logic              rst_q1;
  logic              rst_sync_n;
  logic              drop_q1;
  logic              drop_sync;
  logic [DATA_W-1:0] gpr_mem [GPR_TOTAL];
  logic [DATA_W-1:0] common_mem [COMMON_BYTES];

  logic              ar_fire;
  logic              ar_idata;
  logic              wr_go;
  logic              acc_en;
  logic              acc_we;
  logic [PTR_W-1:0]  acc_ptr;
  logic [DATA_W-1:0] acc_wdata;
  logic [DATA_W-1:0] acc_rd;
  bdm_region_e       acc_rgn;
  logic [GIW-1:0]    acc_gidx;
  logic [DATA_W-1:0] alu_res;
  logic              alu_zero;
  logic              alu_nib;
  logic              alu_msb;

  // Locations not listed here, including the remaining core registers and
  // program memory seen through the pointer, answer with zero.
  function automatic bdm_region_e decode(input logic [PTR_W-1:0] p);
    logic [OFF_W-1:0]  off;
    logic [BANK_W-1:0] bnk;
    logic [PTR_W-1:0]  lin;
    off    = p[OFF_W-1:0];
    bnk    = p[OFF_W+BANK_W-1:OFF_W];
    lin    = p - LINEAR_BASE;
    decode = RGN_NONE;
    if (p[PTR_PROG_BIT]) begin
      decode = RGN_NONE;
    end else if (p >= LINEAR_BASE) begin
      if (lin < PTR_W'(GPR_TOTAL)) begin
        decode = RGN_GPR;
      end
    end else if (p < BANKED_LIMIT) begin
      if (off == OFF_STATUS) begin
        decode = RGN_STATUS;
      end else if (off == OFF_PTR_LO) begin
        decode = RGN_PTR_LO;
      end else if (off == OFF_PTR_HI) begin
        decode = RGN_PTR_HI;
      end else if (off == OFF_BANK_SEL) begin
        decode = RGN_BANK;
      end else if (off <= OFF_CORE_LAST) begin
        decode = RGN_NONE;
      end else if (off <= OFF_PERIPH_END) begin
        decode = RGN_PERIPH;
      end else if (off <= OFF_GPR_LAST) begin
        if (int'(bnk) < GPR_BANKS) begin
          decode = RGN_GPR;
        end
      end else begin
        decode = RGN_COMMON;
      end
    end
  endfunction

  function automatic logic [GIW-1:0] gpr_index(input logic [PTR_W-1:0] p);
    logic [PTR_W-1:0] idx;
    if (p >= LINEAR_BASE) begin
      idx = p - LINEAR_BASE;
    end else begin
      idx = PTR_W'(p[OFF_W+BANK_W-1:OFF_W]) * PTR_W'(GPR_BYTES)
            + PTR_W'(p[OFF_W-1:0]) - PTR_W'(OFF_GPR_FIRST);
    end
    gpr_index = idx[GIW-1:0];
  endfunction

  function automatic logic [DATA_W-1:0] status_byte(input bdm_state_s st);
    status_byte            = '0;
    status_byte[BIT_WDT]   = st.wdt_n;
    status_byte[BIT_SLEEP] = st.sleep_n;
    status_byte[BIT_Z]     = st.z;
    status_byte[BIT_DC]    = st.dc;
    status_byte[BIT_C]     = st.c;
  endfunction

  bdm_alu_flags u_alu (
    .kind      (alu_kind),
    .a         (alu_a),
    .b         (alu_b),
    .logic_res (alu_logic_res),
    .result    (alu_res),
    .zero      (alu_zero),
    .nib_carry (alu_nib),
    .msb_carry (alu_msb)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q1     <= 1'b0;
      rst_sync_n <= 1'b0;
    end else if (clk_en) begin
      rst_q1     <= 1'b1;
      rst_sync_n <= rst_q1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      drop_q1   <= 1'b0;
      drop_sync <= 1'b0;
    end else if (clk_en) begin
      drop_q1   <= supply_drop_reset;
      drop_sync <= drop_q1;
    end
  end

  // The core has priority on the access path; the bus waits for a free cycle.
  // No channel is taken while the internal reset still holds the state.
  assign s_axi_awready = clk_en && rst_sync_n && !s.aw_got && !s.bvalid;
  assign s_axi_wready  = clk_en && rst_sync_n && !s.w_got && !s.bvalid;
  assign s_axi_arready = clk_en && rst_sync_n && !s.rvalid && !mem_req;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign ar_idata      = (s_axi_araddr == AXI_IDATA);
  assign wr_go         = s.aw_got && s.w_got && !s.bvalid && !mem_req
                         && !(ar_fire && ar_idata);

  always_comb begin
    acc_en    = 1'b0;
    acc_we    = 1'b0;
    acc_ptr   = s.ptr;
    acc_wdata = mem_wdata;
    if (mem_req) begin
      acc_en  = 1'b1;
      acc_we  = mem_we;
      acc_ptr = mem_indirect ? s.ptr : PTR_W'({s.bank, mem_offset});
    end else if (ar_fire && ar_idata) begin
      acc_en  = 1'b1;
    end else if (wr_go && s.aw_addr == AXI_IDATA && s.w_strb[0]) begin
      acc_en    = 1'b1;
      acc_we    = 1'b1;
      acc_wdata = s.w_data[DATA_W-1:0];
    end
  end

  assign acc_rgn  = decode(acc_ptr);
  assign acc_gidx = gpr_index(acc_ptr);

  always_comb begin
    case (acc_rgn)
      RGN_STATUS: acc_rd = status_byte(s);
      RGN_PTR_LO: acc_rd = s.ptr[DATA_W-1:0];
      RGN_PTR_HI: acc_rd = s.ptr[PTR_W-1:DATA_W];
      RGN_BANK:   acc_rd = DATA_W'(s.bank);
      RGN_GPR:    acc_rd = gpr_mem[acc_gidx];
      RGN_COMMON: acc_rd = common_mem[acc_ptr[COMMON_IDX_W-1:0]];
      default:    acc_rd = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (clk_en && acc_en && acc_we) begin
      if (acc_rgn == RGN_GPR) begin
        gpr_mem[acc_gidx] <= acc_wdata;
      end
      if (acc_rgn == RGN_COMMON) begin
        common_mem[acc_ptr[COMMON_IDX_W-1:0]] <= acc_wdata;
      end
    end
  end

  always_comb begin
    next_s = s;
    // Register writes through the access path, from the core port or from bus indirect data.
    if (acc_en && acc_we) begin
      case (acc_rgn)
        RGN_STATUS: begin
          if (!alu_valid) begin
            next_s.z  = acc_wdata[BIT_Z];
            next_s.dc = acc_wdata[BIT_DC];
            next_s.c  = acc_wdata[BIT_C];
          end
        end
        RGN_PTR_LO: next_s.ptr[DATA_W-1:0]     = acc_wdata;
        RGN_PTR_HI: next_s.ptr[PTR_W-1:DATA_W] = acc_wdata;
        RGN_BANK:   next_s.bank                = acc_wdata[BANK_W-1:0];
        default:    next_s.bank                = s.bank;
      endcase
    end
    if (mem_req && !mem_we) begin
      next_s.mem_rdata = acc_rd;
    end
    next_s.periph_sel = acc_en && (acc_rgn == RGN_PERIPH);
    if (acc_en && acc_rgn == RGN_PERIPH) begin
      next_s.periph_addr = acc_ptr[11:0];
    end
    // Register writes from the bus; the power flags are never writable.
    if (wr_go && s.w_strb[0]) begin
      if (s.aw_addr == AXI_STATUS && !alu_valid) begin
        next_s.z  = s.w_data[BIT_Z];
        next_s.dc = s.w_data[BIT_DC];
        next_s.c  = s.w_data[BIT_C];
      end
      if (s.aw_addr == AXI_BANK_SEL) begin
        next_s.bank = s.w_data[BANK_W-1:0];
      end
      if (s.aw_addr == AXI_PTR) begin
        next_s.ptr[DATA_W-1:0] = s.w_data[DATA_W-1:0];
      end
    end
    if (wr_go && s.w_strb[1] && s.aw_addr == AXI_PTR) begin
      next_s.ptr[PTR_W-1:DATA_W] = s.w_data[PTR_W-1:DATA_W];
    end
    // The arithmetic unit overrides any write to its own flags.
    if (alu_valid) begin
      next_s.alu_result = alu_res;
      next_s.z          = alu_zero;
      if (alu_kind != ALU_LOGIC) begin
        next_s.dc = alu_nib;
        next_s.c  = alu_msb;
      end
    end
    // An expiry in the same cycle as a clear still leaves its mark.
    if (sleep_instr) begin
      next_s.wdt_n   = 1'b1;
      next_s.sleep_n = 1'b0;
    end
    if (watchdog_clear_instr) begin
      next_s.wdt_n   = 1'b1;
      next_s.sleep_n = 1'b1;
    end
    if (watchdog_expire) begin
      next_s.wdt_n = 1'b0;
    end
    if (drop_sync) begin
      next_s.wdt_n   = RST_POWER_FLAG;
      next_s.sleep_n = RST_POWER_FLAG;
      next_s.z       = RST_ARITH_FLAG;
      next_s.dc      = RST_ARITH_FLAG;
      next_s.c       = RST_ARITH_FLAG;
    end
    // Bus channel bookkeeping.
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got  = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = (s.aw_addr == AXI_STATUS || s.aw_addr == AXI_BANK_SEL
                       || s.aw_addr == AXI_PTR || s.aw_addr == AXI_IDATA)
                      ? RESP_OKAY : RESP_SLVERR;
    end else if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (ar_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        AXI_STATUS:   next_s.rdata = 32'(status_byte(s));
        AXI_BANK_SEL: next_s.rdata = 32'(s.bank);
        AXI_PTR:      next_s.rdata = 32'(s.ptr);
        AXI_IDATA:    next_s.rdata = 32'(acc_rd);
        default: begin
          next_s.rdata = '0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s         <= '0;
      s.wdt_n   <= RST_POWER_FLAG;
      s.sleep_n <= RST_POWER_FLAG;
      s.z       <= RST_ARITH_FLAG;
      s.dc      <= RST_ARITH_FLAG;
      s.c       <= RST_ARITH_FLAG;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign mem_rdata            = s.mem_rdata;
  assign alu_result           = s.alu_result;
  assign arith_reset_status   = status_byte(s);
  assign bank_select_register = s.bank;
  assign periph_sel           = s.periph_sel;
  assign periph_addr          = s.periph_addr;
  assign s_axi_bresp          = s.bresp;
  assign s_axi_bvalid         = s.bvalid;
  assign s_axi_rdata          = s.rdata;
  assign s_axi_rresp          = s.rresp;
  assign s_axi_rvalid         = s.rvalid;

endmodule

// ===== sim/bdm_properties.sv
`timescale 1ns/1ps
module bdm_properties
  import bdm_pkg::*;
#(
  parameter int GPR_BANKS = 6
)
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              clk_en,
  input wire logic              supply_drop_reset,
  input wire logic              watchdog_clear_instr,
  input wire logic              sleep_instr,
  input wire logic              watchdog_expire,
  input wire logic              mem_req,
  input wire logic              mem_we,
  input wire logic              mem_indirect,
  input wire logic [OFF_W-1:0]  mem_offset,
  input wire logic [DATA_W-1:0] mem_wdata,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic              alu_valid,
  input wire bdm_alu_e          alu_kind,
  input wire logic [DATA_W-1:0] alu_a,
  input wire logic [DATA_W-1:0] alu_b,
  input wire logic [DATA_W-1:0] alu_logic_res,
  input wire logic [DATA_W-1:0] alu_result,
  input wire logic [DATA_W-1:0] arith_reset_status,
  input wire logic [BANK_W-1:0] bank_select_register,
  input wire logic              periph_sel
);
  logic [1:0] rcnt;
  logic [3:0] sdq;
  logic [7:0] q_res;
  logic [7:0] q_wd;
  logic [2:0] q_fl;
  logic       ok;
  logic       sub;
  logic [7:0] bb;
  logic [8:0] sum;
  logic [4:0] nib;
  logic       zr;
  assign sub = alu_kind == ALU_SUB;
  assign bb  = sub ? ~alu_b : alu_b;
  assign sum = {1'b0, alu_a} + {1'b0, bb} + 9'(sub);
  assign nib = {1'b0, alu_a[3:0]} + {1'b0, bb[3:0]} + 5'(sub);
  assign zr  = (alu_kind == ALU_LOGIC) ? alu_logic_res == 8'h00 : sum[7:0] == 8'h00;
  // Checks other than the top-bit and supply-drop ones are held off until the internal reset and supply-drop syncs have settled.
  assign ok  = rcnt == 2'd3 && clk_en && sdq == 4'h0 && !supply_drop_reset;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rcnt <= 2'd0;
      sdq  <= 4'h0;
    end else begin
      rcnt <= (rcnt == 2'd3) ? rcnt : rcnt + 2'd1;
      sdq  <= {sdq[2:0], supply_drop_reset};
    end
  end
  always_ff @(posedge clk) begin
    q_res <= (alu_kind == ALU_LOGIC) ? alu_logic_res : sum[7:0];
    q_fl  <= {zr, nib[4], sum[8]};
    q_wd  <= mem_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_dir(logic w, logic [OFF_W-1:0] o);
    ok && mem_req && !mem_indirect && mem_we == w && mem_offset == o;
  endsequence
  sequence s_logic;
    ok && alu_valid && alu_kind == ALU_LOGIC;
  endsequence
  sequence s_per;
    ok && mem_req && !mem_we && !mem_indirect && mem_offset inside {[7'h0c:7'h1f]};
  endsequence
  AST_TOP_ZERO: assert property (
    arith_reset_status[7:5] == 3'b000) else $error("status top bits set");
  AST_EXPIRE: assert property (
    ok && watchdog_expire |=> !arith_reset_status[BIT_WDT]) else $error("expiry flag");
  AST_SLEEP: assert property (
    ok && sleep_instr && !watchdog_expire && !watchdog_clear_instr
    |=> arith_reset_status[4:3] == 2'b10) else $error("sleep flags");
  AST_CLEAR: assert property (
    ok && watchdog_clear_instr && !watchdog_expire
    |=> arith_reset_status[4:3] == 2'b11) else $error("clear flags");
  AST_SUPPLY: assert property (
    (supply_drop_reset && clk_en) [*4] |=> arith_reset_status[4:0] == 5'h18)
    else $error("supply drop flags");
  AST_ARITH: assert property (
    ok && alu_valid && alu_kind != ALU_LOGIC
    |=> arith_reset_status[2:0] == q_fl && alu_result == q_res) else $error("arith flags");
  AST_LOGIC: assert property (
    s_logic |=> arith_reset_status[BIT_Z] == q_fl[2] && $stable(arith_reset_status[1:0]))
    else $error("logic flags");
  AST_WR_STATUS: assert property (
    s_dir(1'b1, OFF_STATUS) and !alu_valid && !sleep_instr && !watchdog_clear_instr
    && !watchdog_expire |=> $stable(arith_reset_status[4:3])
    && arith_reset_status[2:0] == q_wd[2:0]) else $error("status write");
  AST_BANK: assert property (
    s_dir(1'b1, OFF_BANK_SEL) |=> bank_select_register == q_wd[4:0]) else $error("bank");
  AST_PERIPH: assert property (
    s_per |=> mem_rdata == 8'h00 && periph_sel) else $error("peripheral area");
  AST_CORE_ZERO: assert property (
    s_dir(1'b0, OFF_CORE_LAST) |=> mem_rdata == 8'h00) else $error("core zero");
endmodule
bind bdm_top bdm_properties #(.GPR_BANKS(GPR_BANKS)) props (
  .clk, .reset_n, .clk_en, .supply_drop_reset, .watchdog_clear_instr, .sleep_instr,
  .watchdog_expire, .mem_req, .mem_we, .mem_indirect, .mem_offset, .mem_wdata, .mem_rdata,
  .alu_valid, .alu_kind, .alu_a, .alu_b, .alu_logic_res, .alu_result, .arith_reset_status,
  .bank_select_register, .periph_sel
);

// ===== sim/banked_data_memory_status_tb.sv
`timescale 1ns/1ps
module banked_data_memory_status_tb;
  import bdm_pkg::*;
  typedef struct packed {
    bdm_alu_e   kind;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] lr;
    logic [7:0] res;
    logic [2:0] fl;
  } bdm_row_s;
  logic        clk, reset_n, clk_en, supply_drop_reset, watchdog_clear_instr, sleep_instr;
  logic        watchdog_expire, mem_req, mem_we, mem_indirect, alu_valid, periph_sel;
  logic [6:0]  mem_offset;
  logic [7:0]  mem_wdata, mem_rdata, alu_a, alu_b, alu_logic_res, alu_result;
  logic [7:0]  arith_reset_status, s_axi_awaddr, s_axi_araddr;
  logic [4:0]  bank_select_register;
  logic [11:0] periph_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  bdm_alu_e    alu_kind;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  bdm_row_s    rows [8] = '{
    '{ALU_ADD, 8'h0f, 8'h01, 8'h00, 8'h10, 3'b010},
    '{ALU_ADD, 8'hff, 8'h01, 8'h00, 8'h00, 3'b111},
    '{ALU_ADD, 8'h80, 8'h80, 8'h00, 8'h00, 3'b101},
    '{ALU_SUB, 8'h05, 8'h05, 8'h00, 8'h00, 3'b111},
    '{ALU_SUB, 8'h03, 8'h05, 8'h00, 8'hfe, 3'b000},
    '{ALU_SUB, 8'h10, 8'h01, 8'h00, 8'h0f, 3'b001},
    '{ALU_LOGIC, 8'h00, 8'h00, 8'h00, 8'h00, 3'b101},
    '{ALU_LOGIC, 8'h00, 8'h00, 8'h5a, 8'h5a, 3'b001}
  };
  bdm_top #(.GPR_BANKS(6)) uut (
    .clk, .reset_n, .clk_en, .supply_drop_reset, .watchdog_clear_instr, .sleep_instr,
    .watchdog_expire, .mem_req, .mem_we, .mem_indirect, .mem_offset, .mem_wdata, .mem_rdata,
    .alu_valid, .alu_kind, .alu_a, .alu_b, .alu_logic_res, .alu_result, .arith_reset_status,
    .bank_select_register, .periph_sel, .periph_addr, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic results();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic we, input logic ind, input logic [6:0] off, input logic [7:0] d);
    @(posedge clk);
    {mem_req, mem_we, mem_indirect, mem_offset, mem_wdata} <= {1'b1, we, ind, off, d};
    @(posedge clk);
    mem_req <= 1'b0;
    #1;
  endtask
  task automatic cw(input logic [6:0] off, input logic [7:0] d);
    acc(1'b1, 1'b0, off, d);
  endtask
  task automatic cr(input logic ind, input logic [6:0] off, input logic [7:0] e);
    acc(1'b0, ind, off, 8'h00);
    chk("mem_rdata", mem_rdata, e);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, er);
  endtask
  task automatic alu(input bdm_row_s r);
    alu_valid <= 1'b1;
    alu_kind <= r.kind;
    {alu_a, alu_b, alu_logic_res} <= {r.a, r.b, r.lr};
    @(posedge clk);
    {alu_valid, mem_req} <= 2'b00;
    #1;
    chk("alu_result", alu_result, r.res);
    chk("status", arith_reset_status, {5'b00011, r.fl});
  endtask
  task automatic pls(input logic [2:0] v, input logic [1:0] e);
    @(posedge clk);
    {watchdog_expire, sleep_instr, watchdog_clear_instr} <= v;
    @(posedge clk);
    {watchdog_expire, sleep_instr, watchdog_clear_instr} <= 3'b000;
    #1;
    chk("power flags", arith_reset_status[4:3], e);
  endtask
  initial begin
    {reset_n, clk_en, supply_drop_reset, watchdog_clear_instr, sleep_instr} = 5'b01000;
    {watchdog_expire, mem_req, mem_we, mem_indirect, alu_valid} = 5'b00000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00000;
    {mem_offset, mem_wdata, alu_a, alu_b, alu_logic_res} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    alu_kind = ALU_ADD;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("status", arith_reset_status, 8'h18);
    foreach (rows[i]) begin
      @(posedge clk);
      alu(rows[i]);
    end
    cw(OFF_STATUS, 8'hfe);
    chk("status", arith_reset_status, 8'h1e);
    @(posedge clk);
    {mem_req, mem_we, mem_indirect, mem_offset, mem_wdata} <= {3'b110, OFF_STATUS, 8'h00};
    alu(rows[0]);
    pls(3'b010, 2'b10);
    pls(3'b100, 2'b00);
    pls(3'b001, 2'b11);
    pls(3'b100, 2'b01);
    pls(3'b010, 2'b10);
    @(posedge clk);
    supply_drop_reset <= 1'b1;
    repeat (4) @(posedge clk);
    supply_drop_reset <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("status", arith_reset_status, 8'h18);
    @(posedge clk);
    clk_en <= 1'b0;
    pls(3'b100, 2'b11);
    clk_en <= 1'b1;
    axr(AXI_STATUS, 32'h18, RESP_OKAY);
    cw(OFF_BANK_SEL, 8'h01);
    cw(7'h20, 8'ha5);
    axw(AXI_BANK_SEL, 32'h0, RESP_OKAY);
    chk("bank", bank_select_register, 5'h00);
    cw(7'h20, 8'h3c);
    cw(7'h70, 8'h77);
    cr(1'b0, 7'h20, 8'h3c);
    cw(OFF_BANK_SEL, 8'h01);
    cr(1'b0, 7'h20, 8'ha5);
    axw(AXI_BANK_SEL, 32'hff, RESP_OKAY);
    chk("bank", bank_select_register, 5'h1f);
    cr(1'b0, 7'h70, 8'h77);
    cr(1'b0, 7'h20, 8'h00);
    cr(1'b0, OFF_CORE_LAST, 8'h00);
    cr(1'b0, OFF_STATUS, 8'h18);
    cr(1'b0, 7'h0c, 8'h00);
    chk("periph_sel", periph_sel, 1'b1);
    chk("periph_addr", periph_addr, 12'hf8c);
    cr(1'b0, 7'h1f, 8'h00);
    cw(OFF_BANK_SEL, 8'h06);
    cr(1'b0, 7'h20, 8'h00);
    axw(AXI_PTR, 32'h2050, RESP_OKAY);
    axr(AXI_IDATA, 32'ha5, RESP_OKAY);
    cr(1'b1, 7'h00, 8'ha5);
    axw(AXI_PTR, 32'h2000, RESP_OKAY);
    cr(1'b1, 7'h00, 8'h3c);
    axw(AXI_PTR, 32'h00a0, RESP_OKAY);
    cr(1'b1, 7'h00, 8'ha5);
    cw(OFF_PTR_HI, 8'h20);
    cw(OFF_PTR_LO, 8'h00);
    cr(1'b0, OFF_PTR_HI, 8'h20);
    cr(1'b1, 7'h00, 8'h3c);
    axw(8'h10, 32'h0, RESP_SLVERR);
    axr(8'h10, 32'h0, RESP_SLVERR);
    results();
  end
endmodule
